/* File: cam_core.sv */
// Operand fetch, effective-address and multiply unit of the CPU
`timescale 1ns/1ps
`default_nettype none
module cam_core
  import cam_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Decode-stage request
  input wire logic start_in,
  input wire logic [2:0] mode_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_in,
  input wire logic branch_cond_in,
  output logic busy_out,
  // Decode-stage result
  output logic done_out,
  output logic [15:0] ea_out,
  output logic [7:0] operand_out,
  output logic use_mem_out,
  output logic [1:0] length_out,
  output logic [15:0] next_pc_out,
  output logic branch_taken_out,
  // Program memory read port
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  // Multiply request and result
  input wire logic mul_start_in,
  input wire logic [7:0] mul_acc_in,
  input wire logic [7:0] mul_index_in,
  output logic mul_done_out,
  output logic [7:0] mul_acc_out,
  output logic [7:0] mul_index_out
);

  cam_state_t state, next_state;
  cam_mode_t mode_q, next_mode_q;
  cam_mode_t req_mode;
  logic [15:0] pc_q, next_pc_q;
  logic [7:0] idx_q, next_idx_q;
  logic [7:0] b1_q, next_b1_q;
  logic [7:0] b2_q, next_b2_q;
  logic cond_q, next_cond_q;
  logic [1:0] len_q, next_len_q;
  logic [1:0] req_len;
  logic next_mem_rd;
  logic [15:0] next_mem_addr;
  logic next_done;
  logic [15:0] next_ea;
  logic [7:0] next_operand;
  logic next_use_mem;
  logic [1:0] next_length;
  logic [15:0] next_npc;
  logic next_taken;
  logic [15:0] calc_ea;
  logic calc_use_mem;
  logic calc_taken;
  logic [15:0] calc_npc;
  logic next_mul_done;
  logic [7:0] next_mul_acc, next_mul_index;
  logic [7:0] prod_high, prod_low;

  // The 3-bit mode field spans exactly the eight modes
  assign req_mode = cam_mode_t'(mode_in);
  assign req_len = cam_length(req_mode);
  assign busy_out = (state != S_IDLE);

  cam_ea_calc u_ea (
    .mode_in(mode_q),
    .pc_in(pc_q),
    .index_in(idx_q),
    .byte1_in(b1_q),
    .byte2_in(b2_q),
    .cond_in(cond_q),
    .len_in(len_q),
    .ea_out(calc_ea),
    .use_mem_out(calc_use_mem),
    .taken_out(calc_taken),
    .next_pc_out(calc_npc)
  );

  cam_mul u_mul (
    .acc_in(mul_acc_in),
    .index_in(mul_index_in),
    .high_out(prod_high),
    .low_out(prod_low)
  );

  // Fetch sequencer; memory answers one cycle after a read strobe
  always_comb begin
    next_state = state;
    next_mode_q = mode_q;
    next_pc_q = pc_q;
    next_idx_q = idx_q;
    next_b1_q = b1_q;
    next_b2_q = b2_q;
    next_cond_q = cond_q;
    next_len_q = len_q;
    next_mem_rd = 1'b0;
    next_mem_addr = mem_addr_out;
    next_done = 1'b0;
    next_ea = ea_out;
    next_operand = operand_out;
    next_use_mem = use_mem_out;
    next_length = length_out;
    next_npc = next_pc_out;
    next_taken = branch_taken_out;
    case (state)
      S_IDLE: begin
        if (start_in) begin
          next_mode_q = req_mode;
          next_pc_q = pc_in;
          next_idx_q = index_in;
          next_cond_q = branch_cond_in;
          next_len_q = req_len;
          next_b1_q = RST_BYTE;
          next_b2_q = RST_BYTE;
          if (req_len == LEN_ONE) begin
            next_state = S_CALC;
          end else begin
            next_mem_rd = 1'b1;
            next_mem_addr = pc_in + PC_STEP;
            next_state = S_WAIT1;
          end
        end
      end
      S_WAIT1: next_state = S_BYTE1;
      S_BYTE1: begin
        next_b1_q = mem_data_in;
        if (len_q == LEN_THREE) begin
          next_mem_rd = 1'b1;
          next_mem_addr = pc_q + PC_STEP + PC_STEP;
          next_state = S_WAIT2;
        end else begin
          next_state = S_CALC;
        end
      end
      S_WAIT2: next_state = S_BYTE2;
      S_BYTE2: begin
        next_b2_q = mem_data_in;
        next_state = S_CALC;
      end
      S_CALC: begin
        next_done = 1'b1;
        next_ea = calc_ea;
        // Only immediate mode hands a literal back; the memory modes read at ea_out
        next_operand = (mode_q == AM_IMM) ? b1_q : RST_BYTE;
        next_use_mem = calc_use_mem;
        next_length = len_q;
        next_npc = calc_npc;
        next_taken = calc_taken;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      mode_q <= AM_INH;
      pc_q <= RST_ADDR;
      idx_q <= RST_BYTE;
      b1_q <= RST_BYTE;
      b2_q <= RST_BYTE;
      cond_q <= 1'b0;
      len_q <= LEN_ONE;
      mem_rd_out <= 1'b0;
      mem_addr_out <= RST_ADDR;
      done_out <= 1'b0;
      ea_out <= RST_ADDR;
      operand_out <= RST_BYTE;
      use_mem_out <= 1'b0;
      length_out <= LEN_ONE;
      next_pc_out <= RST_ADDR;
      branch_taken_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      mode_q <= next_mode_q;
      pc_q <= next_pc_q;
      idx_q <= next_idx_q;
      b1_q <= next_b1_q;
      b2_q <= next_b2_q;
      cond_q <= next_cond_q;
      len_q <= next_len_q;
      mem_rd_out <= next_mem_rd;
      mem_addr_out <= next_mem_addr;
      done_out <= next_done;
      ea_out <= next_ea;
      operand_out <= next_operand;
      use_mem_out <= next_use_mem;
      length_out <= next_length;
      next_pc_out <= next_npc;
      branch_taken_out <= next_taken;
    end
  end

  // Multiply is single cycle and independent of the fetch sequencer
  always_comb begin
    next_mul_done = mul_start_in;
    next_mul_acc = mul_acc_out;
    next_mul_index = mul_index_out;
    if (mul_start_in) begin
      next_mul_acc = prod_low;
      next_mul_index = prod_high;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mul_done_out <= 1'b0;
      mul_acc_out <= RST_BYTE;
      mul_index_out <= RST_BYTE;
    end else if (ce_in) begin
      mul_done_out <= next_mul_done;
      mul_acc_out <= next_mul_acc;
      mul_index_out <= next_mul_index;
    end
  end

  // Checks; cycles with the enable low are skipped by all but chk_ce_freeze
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in || !ce_in);

  chk_inh_no_fetch: assert property (
    (state == S_IDLE) && start_in && (req_mode == AM_INH)
    |=> (state == S_CALC) && !mem_rd_out ##1 done_out && !use_mem_out)
    else $error("inherent instruction fetched or formed an address");

  chk_imm_literal: assert property (
    done_out && (mode_q == AM_IMM)
    |-> (operand_out == b1_q) && !use_mem_out && (length_out == LEN_TWO))
    else $error("immediate literal not returned");

  chk_direct_page: assert property (
    done_out && (mode_q == AM_DIR) |-> (ea_out == {ZERO_PAGE, b1_q}))
    else $error("direct address not in page zero");

  chk_ext_fetch: assert property (
    (state == S_IDLE) && start_in && (req_mode == AM_EXT)
    |=> mem_rd_out && (mem_addr_out == $past(pc_in) + PC_STEP)
    ##2 mem_rd_out && (mem_addr_out == pc_q + PC_STEP + PC_STEP)
    ##3 done_out && (ea_out == {b1_q, b2_q}))
    else $error("extended fetch order or address wrong");

  chk_ix_zero_high: assert property (
    done_out && (mode_q == AM_IX)
    |-> (ea_out == {ZERO_PAGE, idx_q}) && (length_out == LEN_ONE))
    else $error("indexed no-offset address wrong");

  chk_ix1_carry: assert property (
    done_out && (mode_q == AM_IX1)
    |-> (ea_out == ({ZERO_PAGE, b1_q} + {ZERO_PAGE, idx_q})) && (ea_out <= IX1_TOP))
    else $error("8-bit offset indexed sum wrong");

  chk_ix2_sum: assert property (
    done_out && (mode_q == AM_IX2)
    |-> (ea_out == ({b1_q, b2_q} + {ZERO_PAGE, idx_q})) && (length_out == LEN_THREE))
    else $error("16-bit offset indexed sum wrong");

  chk_branch_target: assert property (
    done_out && (mode_q == AM_REL)
    |-> (next_pc_out == (cond_q ? pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q}
                                : pc_q + 16'h0002)) && (branch_taken_out == cond_q))
    else $error("branch target wrong");

  chk_mul_place: assert property (
    mul_start_in |=> mul_done_out &&
    ({mul_index_out, mul_acc_out} == {ZERO_PAGE, $past(mul_acc_in)} *
                                     {ZERO_PAGE, $past(mul_index_in)}))
    else $error("multiply result placement wrong");

  chk_mode_count: assert property (
    done_out |-> (length_out == ((mode_q inside {AM_INH, AM_IX}) ? LEN_ONE :
                                 (mode_q inside {AM_EXT, AM_IX2}) ? LEN_THREE : LEN_TWO)))
    else $error("mode length decode wrong");

  // Memory has no wait input, so strobes must leave it a cycle to answer
  chk_rd_spacing: assert property (
    mem_rd_out |=> !mem_rd_out)
    else $error("read strobes closer than two cycles");

  chk_ce_freeze: assert property (
    disable iff (rst_in) !ce_in |=> $stable(state) && $stable(done_out) && $stable(mul_acc_out))
    else $error("state moved while enable low");

  cov_branch_taken: cover property (done_out && (mode_q == AM_REL) && branch_taken_out);
  cov_ext_done: cover property (done_out && (mode_q == AM_EXT));
  cov_ix1_page1: cover property (done_out && (mode_q == AM_IX1) && ea_out[8]);
  cov_mul: cover property (mul_start_in ##1 mul_done_out && (mul_index_out != RST_BYTE));

endmodule
`default_nettype wire

/* File: cam_pkg.sv */
// Shared types and constants for the operand fetch and effective-address unit
package cam_pkg;

  // Eight addressing modes
  typedef enum logic [2:0] {
    AM_INH = 3'b000,
    AM_IMM = 3'b001,
    AM_DIR = 3'b010,
    AM_EXT = 3'b011,
    AM_IX  = 3'b100,
    AM_IX1 = 3'b101,
    AM_IX2 = 3'b110,
    AM_REL = 3'b111
  } cam_mode_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_WAIT1 = 3'b001,
    S_BYTE1 = 3'b010,
    S_WAIT2 = 3'b011,
    S_BYTE2 = 3'b100,
    S_CALC  = 3'b101
  } cam_state_t;

  localparam int CAM_NUM_INSTR = 62;
  localparam int CAM_NUM_MODES = 8;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] IX1_TOP = 16'h01fe;

  // Instruction length in bytes, opcode included
  function automatic logic [1:0] cam_length(input cam_mode_t m);
    logic [1:0] len;
    len = LEN_ONE;
    case (m)
      AM_INH, AM_IX: len = LEN_ONE;
      AM_EXT, AM_IX2: len = LEN_THREE;
      default: len = LEN_TWO;
    endcase
    return len;
  endfunction

endpackage

/* File: cam_ea_calc.sv */
// Effective-address and branch-target arithmetic for all addressing modes
`timescale 1ns/1ps
`default_nettype none
module cam_ea_calc
  import cam_pkg::*;
(
  // Captured instruction fields
  input wire cam_mode_t mode_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] byte1_in,
  input wire logic [7:0] byte2_in,
  input wire logic cond_in,
  input wire logic [1:0] len_in,
  // Results
  output logic [15:0] ea_out,
  output logic use_mem_out,
  output logic taken_out,
  output logic [15:0] next_pc_out
);
  logic [15:0] after_pc;
  logic [15:0] offset;

  always_comb begin
    after_pc = pc_in + {14'h0000, len_in};
    offset = {{8{byte1_in[7]}}, byte1_in};
    ea_out = RST_ADDR;
    use_mem_out = 1'b1;
    case (mode_in)
      AM_INH: use_mem_out = 1'b0;
      AM_IMM: use_mem_out = 1'b0;
      AM_DIR: ea_out = {ZERO_PAGE, byte1_in};
      AM_EXT: ea_out = {byte1_in, byte2_in};
      AM_IX: ea_out = {ZERO_PAGE, index_in};
      // Full 16-bit add so the low-byte carry lands in the high byte
      AM_IX1: ea_out = {ZERO_PAGE, byte1_in} + {ZERO_PAGE, index_in};
      AM_IX2: ea_out = {byte1_in, byte2_in} + {ZERO_PAGE, index_in};
      AM_REL: begin
        ea_out = after_pc + offset;
        use_mem_out = 1'b0;
      end
      default: use_mem_out = 1'b0;
    endcase
    taken_out = (mode_in == AM_REL) && cond_in;
    next_pc_out = taken_out ? ea_out : after_pc;
  end
endmodule
`default_nettype wire

/* File: cam_mul.sv */
// Unsigned 8x8 multiplier with split high and low result bytes
`timescale 1ns/1ps
`default_nettype none
module cam_mul
  import cam_pkg::*;
(
  // Factors
  input wire logic [7:0] acc_in,
  input wire logic [7:0] index_in,
  // Product halves
  output logic [7:0] high_out,
  output logic [7:0] low_out
);
  logic [15:0] product;

  assign product = {ZERO_PAGE, acc_in} * {ZERO_PAGE, index_in};
  assign high_out = product[15:8];
  assign low_out = product[7:0];
endmodule
`default_nettype wire

/* File: cam_mem_model.sv */
// Program memory model answering the unit's read strobe one cycle later
`timescale 1ns/1ps
`default_nettype none
module cam_mem_model (
  // Clock
  input wire logic clk_in,
  // Read port
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_data_out
);
  logic [7:0] mem [0:65535];

  initial begin
    mem_data_out = 8'h00;
  end

  // Outside the answer cycle the bus toggles, so a late sample shows up as wrong data
  always @(posedge clk_in) begin
    if (mem_rd_in === 1'b1) begin
      mem_data_out <= mem[mem_addr_in];
    end else begin
      mem_data_out <= ~mem_data_out;
    end
  end
endmodule
`default_nettype wire

/* File: cam_core_tb.sv */
// Self-checking testbench for the operand fetch, effective-address and multiply unit
`timescale 1ns/1ps
`default_nettype none
module cam_core_tb
  import cam_pkg::*;
;
  logic clk_in, rst_in, ce_in, start_in, branch_cond_in, mul_start_in;
  logic [2:0] mode_in;
  logic [15:0] pc_in, ea_out, next_pc_out, mem_addr_out;
  logic [7:0] index_in, operand_out, mem_data_in, mul_acc_in, mul_index_in;
  logic [7:0] mul_acc_out, mul_index_out;
  logic busy_out, done_out, use_mem_out, branch_taken_out, mem_rd_out, mul_done_out;
  logic [1:0] length_out;
  int error_cnt, n_tests, rd_cnt;

  cam_core cam_core_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .start_in(start_in), .mode_in(mode_in), .pc_in(pc_in), .index_in(index_in),
    .branch_cond_in(branch_cond_in), .busy_out(busy_out), .done_out(done_out),
    .ea_out(ea_out), .operand_out(operand_out), .use_mem_out(use_mem_out),
    .length_out(length_out), .next_pc_out(next_pc_out),
    .branch_taken_out(branch_taken_out), .mem_rd_out(mem_rd_out),
    .mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in),
    .mul_start_in(mul_start_in), .mul_acc_in(mul_acc_in), .mul_index_in(mul_index_in),
    .mul_done_out(mul_done_out), .mul_acc_out(mul_acc_out),
    .mul_index_out(mul_index_out));

  cam_mem_model cam_mem_model_inst (.clk_in(clk_in), .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (mem_rd_out === 1'b1) begin
      rd_cnt++;
    end
  end

  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bytes that follow the opcode at address a
  task automatic ld(input logic [15:0] a, input logic [7:0] b1, input logic [7:0] b2);
    cam_mem_model_inst.mem[a + 16'h0001] = b1;
    cam_mem_model_inst.mem[a + 16'h0002] = b2;
  endtask

  // One decode request; length and memory use follow from the mode, the taken flag from mode and condition
  task automatic rf(input logic [2:0] m, input logic [15:0] pc, input logic [7:0] ix,
      input logic c, input logic [15:0] e_ea, input logic [7:0] e_op,
      input logic [15:0] e_npc);
    logic [1:0] e_len;
    logic e_use;
    int n;
    e_len = (m == AM_INH || m == AM_IX) ? 2'h1 : (m == AM_EXT || m == AM_IX2) ? 2'h3 : 2'h2;
    e_use = m inside {AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2};
    @(posedge clk_in);
    start_in <= 1'b1;
    mode_in <= m;
    pc_in <= pc;
    index_in <= ix;
    branch_cond_in <= c;
    @(posedge clk_in);
    start_in <= 1'b0;
    rd_cnt = 0;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("wrong value at %0t: no done", $time);
      test_done();
    end
    cmp(16'(n), {13'h0, e_len, 1'b0} - 16'h0001, "latency");
    cmp(16'(busy_out), 16'h0000, "busy");
    cmp(16'(rd_cnt), 16'(e_len) - 16'h0001, "reads");
    cmp(16'(length_out), 16'(e_len), "length");
    cmp(ea_out, e_ea, "address");
    cmp(16'(operand_out), 16'(e_op), "operand");
    cmp(16'(use_mem_out), 16'(e_use), "use mem");
    cmp(next_pc_out, e_npc, "next pc");
    cmp(16'(branch_taken_out), 16'((m == AM_REL) && c), "taken");
  endtask

  task automatic test_reset();
    cmp(16'(length_out), 16'h0001, "reset length");
    cmp({10'h0, busy_out, done_out, mem_rd_out, mul_done_out, use_mem_out,
      branch_taken_out}, 16'h0000, "reset flags");
    cmp(ea_out | next_pc_out, 16'h0000, "reset address");
  endtask

  task automatic test_inh();
    rf(AM_INH, 16'h0100, 8'h5a, 1'b1, 16'h0000, 8'h00, 16'h0101);
  endtask

  task automatic test_imm();
    ld(16'h0200, 8'ha5, 8'h3c);
    rf(AM_IMM, 16'h0200, 8'h00, 1'b0, 16'h0000, 8'ha5, 16'h0202);
  endtask

  task automatic test_dir();
    ld(16'h0300, 8'hff, 8'h00);
    rf(AM_DIR, 16'h0300, 8'h80, 1'b0, 16'h00ff, 8'h00, 16'h0302);
  endtask

  task automatic test_ext();
    ld(16'h0400, 8'h12, 8'h34);
    rf(AM_EXT, 16'h0400, 8'h01, 1'b0, 16'h1234, 8'h00, 16'h0403);
  endtask

  task automatic test_ix();
    rf(AM_IX, 16'h0500, 8'hc3, 1'b0, 16'h00c3, 8'h00, 16'h0501);
  endtask

  // Both ends of the reachable range and the page crossing
  task automatic test_ix1();
    ld(16'h0600, 8'hff, 8'h00);
    rf(AM_IX1, 16'h0600, 8'hff, 1'b0, 16'h01fe, 8'h00, 16'h0602);
    ld(16'h0610, 8'hff, 8'h00);
    rf(AM_IX1, 16'h0610, 8'h01, 1'b0, 16'h0100, 8'h00, 16'h0612);
    ld(16'h0620, 8'h00, 8'h00);
    rf(AM_IX1, 16'h0620, 8'h00, 1'b0, 16'h0000, 8'h00, 16'h0622);
  endtask

  task automatic test_ix2();
    ld(16'hfff0, 8'h12, 8'hff);
    rf(AM_IX2, 16'hfff0, 8'h01, 1'b0, 16'h1300, 8'h00, 16'hfff3);
  endtask

  task automatic test_rel();
    ld(16'h1000, 8'h80, 8'h00);
    rf(AM_REL, 16'h1000, 8'h00, 1'b1, 16'h0f82, 8'h00, 16'h0f82);
    rf(AM_REL, 16'h1000, 8'h00, 1'b0, 16'h0f82, 8'h00, 16'h1002);
    ld(16'h1000, 8'h7f, 8'h00);
    rf(AM_REL, 16'h1000, 8'h00, 1'b1, 16'h1081, 8'h00, 16'h1081);
    ld(16'h00fe, 8'h02, 8'h00);
    rf(AM_REL, 16'h00fe, 8'h00, 1'b1, 16'h0102, 8'h00, 16'h0102);
  endtask

  // Back-to-back multiplies, each result checked in the cycle after its request
  task automatic test_mul();
    logic [7:0] a [4];
    logic [7:0] x [4];
    a = '{8'hff, 8'h00, 8'h10, 8'h0d};
    x = '{8'hff, 8'hff, 8'h10, 8'h0b};
    for (int i = 0; i <= 4; i++) begin
      @(posedge clk_in);
      mul_start_in <= (i < 4);
      mul_acc_in <= a[i % 4];
      mul_index_in <= x[i % 4];
      if (i > 0) begin
        #1;
        cmp(16'(mul_done_out), 16'h0001, "mul done");
        cmp({mul_index_out, mul_acc_out}, {8'h00, a[i - 1]} * {8'h00, x[i - 1]}, "product");
      end
    end
  endtask

  // Enable low freezes everything, even with requests standing on both ports
  task automatic test_ce();
    @(posedge clk_in);
    ce_in <= 1'b0;
    start_in <= 1'b1;
    mode_in <= AM_INH;
    mul_start_in <= 1'b1;
    mul_acc_in <= 8'h02;
    mul_index_in <= 8'h03;
    @(posedge clk_in);
    #1;
    cmp({15'h0, busy_out}, 16'h0000, "frozen busy");
    cmp({15'h0, mul_done_out}, 16'h0000, "frozen mul done");
    cmp({mul_index_out, mul_acc_out}, 16'h008f, "frozen product");
    @(posedge clk_in);
    ce_in <= 1'b1;
    start_in <= 1'b0;
    mul_start_in <= 1'b0;
  endtask

  initial begin
    error_cnt = 0;
    n_tests = 0;
    rd_cnt = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    start_in = 1'b0;
    mode_in = 3'h0;
    pc_in = 16'h0000;
    index_in = 8'h00;
    branch_cond_in = 1'b0;
    mul_start_in = 1'b0;
    mul_acc_in = 8'h00;
    mul_index_in = 8'h00;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    test_reset();
    test_inh();
    test_imm();
    test_dir();
    test_ext();
    test_ix();
    test_ix1();
    test_ix2();
    test_rel();
    test_mul();
    test_ce();
    test_done();
  end
endmodule
`default_nettype wire
